// *** pkg/csu_dec_if.sv ***
// Decode request and result between the select control and the address decoder.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps

interface csu_dec_if;
	import csu_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic mem_cycle;
	logic boot_en;
	logic low_en;
	logic mid_en;
	logic [BOUND_W-1:0] boot_bound;
	logic [BOUND_W-1:0] low_bound;
	logic [BASE_W-1:0] mid_base;
	logic [BSIZE_W-1:0] mid_size;
	logic boot_hit;
	logic low_hit;
	logic [3:0] mid_hit;
	modport ctrl(output addr, mem_cycle, boot_en, low_en, mid_en, boot_bound, low_bound,
		mid_base, mid_size, input boot_hit, low_hit, mid_hit);
	modport dec(input addr, mem_cycle, boot_en, low_en, mid_en, boot_bound, low_bound,
		mid_base, mid_size, output boot_hit, low_hit, mid_hit);
endinterface

// *** pkg/csu_pkg.sv ***
// Constants, types and register layout shared by the chip-select decoder files.
// Assumes one clock domain with a synchronous active-high reset.
// Functional notes
// - Boot select active on memory cycles when A19:18 are 11 and A17:10 >= bound.
// - Boot register resets to bound FFh, ready honoured, wait count 3.
// - Low select active on memory cycles when A19:18 are 00 and A17:10 < bound.
// - Low register resets to bound 00h and wait count 3.
// - Mid group enabled on memory cycles when A19:13 >= base and the offset from base is below the block size; base has no reset meaning.
// - Ready-ignore clear waits for bus ready; set lets only the wait count decide.
// - At least wait-count wait states go into every cycle that asserts the select.
// - Accessing boot or low register before writing it enables that select.
// - Accessing mid and alternate registers enables the mid selects.
// - Each mid select covers one consecutive quarter of the mid block.
// - Interrupt acknowledge and halt cycles never assert any select.
// - After reset only the boot select is enabled.
package csu_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int REG_ADDR_W = 3;
	localparam logic [REG_ADDR_W-1:0] OFF_BOOT = 3'h0;
	localparam logic [REG_ADDR_W-1:0] OFF_LOW = 3'h1;
	localparam logic [REG_ADDR_W-1:0] OFF_MID = 3'h2;
	localparam logic [REG_ADDR_W-1:0] OFF_ALT = 3'h3;
	localparam logic [REG_ADDR_W-1:0] OFF_STATUS = 3'h4;
	localparam logic [REG_ADDR_W-1:0] OFF_CYCLEN = 3'h5;
	localparam int BOUND_LSB = 6;
	localparam int BOUND_W = 8;
	localparam int BASE_LSB = 9;
	localparam int BASE_W = 7;
	localparam int BSIZE_LSB = 8;
	localparam int BSIZE_W = 7;
	localparam int RDY_IGN_BIT = 2;
	localparam int WAIT_LSB = 0;
	localparam int WAIT_W = 2;
	localparam int CYCLEN_W = 8;
	localparam int ADDR_REGION_LSB = 18;
	localparam int ADDR_BOUND_LSB = 10;
	localparam int ADDR_BASE_LSB = 13;
	localparam logic [1:0] BOOT_REGION = 2'h3;
	localparam logic [1:0] LOW_REGION = 2'h0;
	localparam logic [12:0] MID_PAD = 13'h0000;
	localparam logic [BOUND_W-1:0] BOOT_BOUND_RST = 8'hff;
	localparam logic [BOUND_W-1:0] LOW_BOUND_RST = 8'h00;
	localparam logic [BASE_W-1:0] MID_BASE_RST = 7'h00;
	localparam logic [BSIZE_W-1:0] BSIZE_RST = 7'h00;
	localparam logic [WAIT_W-1:0] WAIT_RST = 2'h3;
	localparam logic RDY_IGN_RST = 1'b0;
	typedef enum logic [2:0] {
		CYC_MEM_READ, CYC_MEM_WRITE, CYC_PREFETCH, CYC_IO_READ,
		CYC_IO_WRITE, CYC_INT_ACK, CYC_HALT, CYC_IDLE
	} csu_cyc_type;
	typedef struct packed {
		logic [BOUND_W-1:0] block_bound_field;
		logic ready_ignore;
		logic [WAIT_W-1:0] wait_count;
	} csu_sel_cfg_type;
	typedef struct packed {
		logic [BASE_W-1:0] block_base_field;
		logic ready_ignore;
		logic [WAIT_W-1:0] wait_count;
	} csu_mid_cfg_type;
endpackage

// *** src/csu_decode.sv ***
// Address decoder for the boot, low and mid selects.
// Assumes the caller gates the result with its own cycle acceptance.
`timescale 1ns/1ps

module csu_decode
	import csu_pkg::*;
(
	// Decode request and result.
	csu_dec_if.dec dif
);

	function automatic logic [1:0] quarter_of(input logic [ADDR_W-1:0] off,
		input logic [ADDR_W-1:0] span);
		logic [ADDR_W-1:0] q1;
		logic [ADDR_W-1:0] q2;
		q1 = span >> 2;
		q2 = span >> 1;
		if (off >= q1 + q2) return 2'h3;
		if (off >= q2) return 2'h2;
		if (off >= q1) return 2'h1;
		return 2'h0;
	endfunction

	logic [ADDR_W-1:0] mid_off;
	logic [ADDR_W-1:0] mid_span;
	logic mid_in;

	// Comparing offsets rather than dividing keeps quarters exact for any block size.
	always_comb begin
		mid_off = dif.addr - {dif.mid_base, MID_PAD};
		mid_span = {dif.mid_size, MID_PAD};
		mid_in = dif.mem_cycle & dif.mid_en & (mid_off < mid_span)
			& (dif.addr[ADDR_BASE_LSB +: BASE_W] >= dif.mid_base);
		dif.boot_hit = dif.mem_cycle & dif.boot_en
			& (dif.addr[ADDR_REGION_LSB +: 2] == BOOT_REGION)
			& (dif.addr[ADDR_BOUND_LSB +: BOUND_W] >= dif.boot_bound);
		dif.low_hit = dif.mem_cycle & dif.low_en
			& (dif.addr[ADDR_REGION_LSB +: 2] == LOW_REGION)
			& (dif.addr[ADDR_BOUND_LSB +: BOUND_W] < dif.low_bound);
		dif.mid_hit = 4'h0;
		if (mid_in) begin
			dif.mid_hit[quarter_of(mid_off, mid_span)] = 1'b1;
		end
	end
endmodule

// *** src/csu_top.sv ***
// Chip-select decoder: select registers, enables and bus cycle sequencing.
// Assumes the processor presents one bus cycle at a time, marked by a start
// pulse, and that the register port and the bus share core_clk.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module csu_top
	import csu_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Register port.
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Bus cycle from the processor.
	input wire logic cyc_start,
	input wire logic [ADDR_W-1:0] cyc_addr,
	input wire csu_cyc_type cyc_type,
	input wire logic bus_ready,
	output logic cyc_done,
	// Select outputs.
	output logic boot_mem_select_n,
	output logic low_mem_select_n,
	output logic [3:0] mid_mem_select_n
);

	typedef struct packed {
		csu_sel_cfg_type boot_cfg;
		csu_sel_cfg_type low_cfg;
		csu_mid_cfg_type mid_cfg;
		logic [BSIZE_W-1:0] mid_size;
		logic boot_en;
		logic low_en;
		logic mid_touched;
		logic alt_touched;
		logic in_cycle;
		logic boot_sel_n;
		logic low_sel_n;
		logic [3:0] mid_sel_n;
		logic [CYCLEN_W-1:0] run_len;
		logic [CYCLEN_W-1:0] last_len;
		logic [DATA_W-1:0] rdata;
	} csu_top_state_type;

	localparam csu_top_state_type RESET_STATE = '{
		boot_cfg: '{
			block_bound_field: BOOT_BOUND_RST,
			ready_ignore: RDY_IGN_RST,
			wait_count: WAIT_RST
		},
		low_cfg: '{
			block_bound_field: LOW_BOUND_RST,
			ready_ignore: RDY_IGN_RST,
			wait_count: WAIT_RST
		},
		mid_cfg: '{
			block_base_field: MID_BASE_RST,
			ready_ignore: RDY_IGN_RST,
			wait_count: WAIT_RST
		},
		mid_size: BSIZE_RST,
		boot_en: 1'b1,
		low_en: 1'b0,
		mid_touched: 1'b0,
		alt_touched: 1'b0,
		in_cycle: 1'b0,
		boot_sel_n: 1'b1,
		low_sel_n: 1'b1,
		mid_sel_n: 4'hf,
		run_len: 8'h00,
		last_len: 8'h00,
		rdata: 16'h0000
	};

	csu_top_state_type st;
	csu_top_state_type next_st;

	csu_dec_if dec_bus ();

	logic accept;
	logic mid_en;
	logic wait_done;
	logic [WAIT_W-1:0] cyc_wait;
	logic cyc_ignore;
	logic [DATA_W-1:0] rd_value;

	function automatic logic [DATA_W-1:0] pack_sel(input csu_sel_cfg_type c);
		logic [DATA_W-1:0] v;
		v = '0;
		v[BOUND_LSB +: BOUND_W] = c.block_bound_field;
		v[RDY_IGN_BIT] = c.ready_ignore;
		v[WAIT_LSB +: WAIT_W] = c.wait_count;
		return v;
	endfunction

	function automatic csu_sel_cfg_type unpack_sel(input logic [DATA_W-1:0] d);
		csu_sel_cfg_type c;
		c.block_bound_field = d[BOUND_LSB +: BOUND_W];
		c.ready_ignore = d[RDY_IGN_BIT];
		c.wait_count = d[WAIT_LSB +: WAIT_W];
		return c;
	endfunction

	function automatic logic [DATA_W-1:0] pack_mid(input csu_mid_cfg_type c);
		logic [DATA_W-1:0] v;
		v = '0;
		v[BASE_LSB +: BASE_W] = c.block_base_field;
		v[RDY_IGN_BIT] = c.ready_ignore;
		v[WAIT_LSB +: WAIT_W] = c.wait_count;
		return v;
	endfunction

	function automatic csu_mid_cfg_type unpack_mid(input logic [DATA_W-1:0] d);
		csu_mid_cfg_type c;
		c.block_base_field = d[BASE_LSB +: BASE_W];
		c.ready_ignore = d[RDY_IGN_BIT];
		c.wait_count = d[WAIT_LSB +: WAIT_W];
		return c;
	endfunction

	function automatic logic is_mem_cycle(input csu_cyc_type t);
		case (t)
			CYC_MEM_READ: return 1'b1;
			CYC_MEM_WRITE: return 1'b1;
			CYC_PREFETCH: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// The mid group needs both its own register and the block size register touched.
	assign mid_en = st.mid_touched & st.alt_touched;

	assign dec_bus.addr = cyc_addr;
	assign dec_bus.mem_cycle = is_mem_cycle(cyc_type);
	assign dec_bus.boot_en = st.boot_en;
	assign dec_bus.low_en = st.low_en;
	assign dec_bus.mid_en = mid_en;
	assign dec_bus.boot_bound = st.boot_cfg.block_bound_field;
	assign dec_bus.low_bound = st.low_cfg.block_bound_field;
	assign dec_bus.mid_base = st.mid_cfg.block_base_field;
	assign dec_bus.mid_size = st.mid_size;

	csu_decode u_decode (
		.dif(dec_bus)
	);

	// A start that overlaps a running cycle is dropped, so the selects and the
	// wait engine always describe exactly one cycle.
	assign accept = cyc_start & ~st.in_cycle;

	// Overlapping ranges are a programming fault; the boot select then sets the
	// timing, then the low select, then the mid group.
	always_comb begin
		cyc_wait = 2'h0;
		cyc_ignore = 1'b0;
		if (dec_bus.boot_hit) begin
			cyc_wait = st.boot_cfg.wait_count;
			cyc_ignore = st.boot_cfg.ready_ignore;
		end else if (dec_bus.low_hit) begin
			cyc_wait = st.low_cfg.wait_count;
			cyc_ignore = st.low_cfg.ready_ignore;
		end else if (dec_bus.mid_hit != 4'h0) begin
			cyc_wait = st.mid_cfg.wait_count;
			cyc_ignore = st.mid_cfg.ready_ignore;
		end
	end

	csu_wait u_wait (
		.core_clk(core_clk),
		.srst(srst),
		.start(accept),
		.wait_count(cyc_wait),
		.ready_ignore(cyc_ignore),
		.bus_ready(bus_ready),
		.done(wait_done)
	);

	// Reserved bits are not stored and read back as zero.
	always_comb begin
		rd_value = '0;
		case (reg_addr)
			OFF_BOOT: begin
				rd_value = pack_sel(st.boot_cfg);
			end
			OFF_LOW: begin
				rd_value = pack_sel(st.low_cfg);
			end
			OFF_MID: begin
				rd_value = pack_mid(st.mid_cfg);
			end
			OFF_ALT: begin
				rd_value[BSIZE_LSB +: BSIZE_W] = st.mid_size;
			end
			OFF_STATUS: begin
				rd_value[0] = st.boot_en;
				rd_value[1] = st.low_en;
				rd_value[2] = mid_en;
				rd_value[3] = st.in_cycle;
				rd_value[4] = ~st.boot_sel_n;
				rd_value[5] = ~st.low_sel_n;
				rd_value[9:6] = ~st.mid_sel_n;
			end
			OFF_CYCLEN: begin
				rd_value[CYCLEN_W-1:0] = st.last_len;
			end
			default: begin
				rd_value = '0;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.rdata = '0;

		if (reg_wr) begin
			case (reg_addr)
				OFF_BOOT: begin
					next_st.boot_cfg = unpack_sel(reg_wdata);
					next_st.boot_en = 1'b1;
				end
				OFF_LOW: begin
					next_st.low_cfg = unpack_sel(reg_wdata);
					next_st.low_en = 1'b1;
				end
				OFF_MID: begin
					next_st.mid_cfg = unpack_mid(reg_wdata);
					next_st.mid_touched = 1'b1;
				end
				OFF_ALT: begin
					next_st.mid_size = reg_wdata[BSIZE_LSB +: BSIZE_W];
					next_st.alt_touched = 1'b1;
				end
				default: begin
					next_st.boot_en = st.boot_en;
				end
			endcase
		end

		// A read alone also enables a select, with whatever its fields hold.
		if (reg_rd) begin
			next_st.rdata = rd_value;
			case (reg_addr)
				OFF_BOOT: begin
					next_st.boot_en = 1'b1;
				end
				OFF_LOW: begin
					next_st.low_en = 1'b1;
				end
				OFF_MID: begin
					next_st.mid_touched = 1'b1;
				end
				OFF_ALT: begin
					next_st.alt_touched = 1'b1;
				end
				default: begin
					next_st.boot_en = st.boot_en;
				end
			endcase
		end

		if (accept) begin
			next_st.in_cycle = 1'b1;
			next_st.boot_sel_n = ~dec_bus.boot_hit;
			next_st.low_sel_n = ~dec_bus.low_hit;
			next_st.mid_sel_n = ~dec_bus.mid_hit;
			next_st.run_len = 8'h01;
		end else if (st.in_cycle) begin
			if (st.run_len != 8'hff) begin
				next_st.run_len = st.run_len + 8'h01;
			end
			if (wait_done) begin
				next_st.in_cycle = 1'b0;
				next_st.boot_sel_n = 1'b1;
				next_st.low_sel_n = 1'b1;
				next_st.mid_sel_n = 4'hf;
				next_st.last_len = st.run_len;
			end
		end
	end

	// Reset leaves only the boot select live, with its documented defaults.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign cyc_done = wait_done;
	assign boot_mem_select_n = st.boot_sel_n;
	assign low_mem_select_n = st.low_sel_n;
	assign mid_mem_select_n = st.mid_sel_n;
endmodule

// *** src/csu_wait.sv ***
// Wait-state engine: counts programmed wait states, then waits for ready if needed.
// Assumes start arrives only while the engine is idle.
`timescale 1ns/1ps

module csu_wait
	import csu_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Cycle control.
	input wire logic start,
	input wire logic [WAIT_W-1:0] wait_count,
	input wire logic ready_ignore,
	input wire logic bus_ready,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic ignore;
		logic [WAIT_W-1:0] remain;
		logic done;
	} csu_wait_state_type;

	csu_wait_state_type st;
	csu_wait_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.busy = 1'b1;
			next_st.ignore = ready_ignore;
			next_st.remain = wait_count;
		end else if (st.busy) begin
			if (st.remain != 2'h0) begin
				next_st.remain = st.remain - 1'b1;
			end else if (st.ignore || bus_ready) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;
endmodule

// *** tb/csu_chk.sv ***
// Checker for csu_top: select decode against tracked registers and wait timing.
// Assumes it is bound to csu_top and sees only its ports.
`timescale 1ns/1ps

module csu_chk
	import csu_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Register port.
	input wire logic [REG_ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Bus cycle.
	input wire logic cyc_start,
	input wire logic [ADDR_W-1:0] cyc_addr,
	input wire csu_cyc_type cyc_type,
	input wire logic bus_ready,
	input wire logic cyc_done,
	// Selects.
	input wire logic boot_mem_select_n,
	input wire logic low_mem_select_n,
	input wire logic [3:0] mid_mem_select_n
);
	logic busy, acc, mem, b_hit, l_hit, cb, cl, cm, lt, mt, at, nosel;
	logic [4:0] cnt, nw;
	logic [7:0] bb, lb;
	logic [2:0] bc, lc, mc, cc;

	assign acc = cyc_start && !busy;
	assign mem = cyc_type inside {CYC_MEM_READ, CYC_MEM_WRITE, CYC_PREFETCH};
	assign b_hit = mem && cyc_addr[19:18] == 2'h3 && cyc_addr[17:10] >= bb;
	assign l_hit = mem && lt && cyc_addr[19:18] == 2'h0 && cyc_addr[17:10] < lb;
	// Timing follows the highest claiming select; a quiet cycle uses no waits.
	assign cc = cb ? bc : cl ? lc : !(&mid_mem_select_n) ? mc : 3'h0;
	assign nw = {3'h0, cc[1:0]} + 5'h2;
	assign nosel = boot_mem_select_n && low_mem_select_n && (&mid_mem_select_n);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy <= 1'b0;
			cnt <= 5'h0;
			cb <= 1'b0;
			cl <= 1'b0;
			cm <= 1'b0;
			bb <= 8'hff;
			bc <= 3'h3;
			lb <= 8'h00;
			lc <= 3'h3;
			mc <= 3'h3;
			lt <= 1'b0;
			mt <= 1'b0;
			at <= 1'b0;
		end else begin
			if (acc) begin
				busy <= 1'b1;
				cnt <= 5'h1;
				cb <= b_hit;
				cl <= l_hit;
				cm <= mem;
			end else if (busy) begin
				cnt <= cnt + 5'h1;
				busy <= !cyc_done;
			end
			if (reg_wr && reg_addr == OFF_BOOT) begin
				bb <= reg_wdata[13:6];
				bc <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == OFF_LOW) begin
				lb <= reg_wdata[13:6];
				lc <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == OFF_MID) begin
				mc <= reg_wdata[2:0];
			end
			if ((reg_wr || reg_rd) && reg_addr == OFF_LOW) begin
				lt <= 1'b1;
			end
			if ((reg_wr || reg_rd) && reg_addr == OFF_MID) begin
				mt <= 1'b1;
			end
			if ((reg_wr || reg_rd) && reg_addr == OFF_ALT) begin
				at <= 1'b1;
			end
		end
	end

	default clocking dck @(posedge core_clk);
	endclocking
	default disable iff (srst);

	property p_boot;
		busy |-> boot_mem_select_n == !cb;
	endproperty
	a_boot: assert property (p_boot) else $error("boot select mismatch");
	property p_low;
		busy |-> low_mem_select_n == !cl;
	endproperty
	a_low: assert property (p_low) else $error("low select mismatch");
	property p_mid_off;
		!(mt && at) |-> &mid_mem_select_n;
	endproperty
	a_mid_off: assert property (p_mid_off) else $error("mid select before enable");
	property p_nosel;
		busy && !cm |-> nosel;
	endproperty
	a_nosel: assert property (p_nosel) else $error("select on non-memory cycle");
	property p_min;
		cyc_done |-> cnt >= nw;
	endproperty
	a_min: assert property (p_min) else $error("too few wait states");
	property p_ign;
		busy && cc[2] |-> cyc_done == (cnt == nw);
	endproperty
	a_ign: assert property (p_ign) else $error("ignored-ready cycle length");
	property p_rdy;
		cyc_done && !cc[2] |-> $past(bus_ready);
	endproperty
	a_rdy: assert property (p_rdy) else $error("cycle ended without ready");
	property p_rdy_end;
		busy && !cc[2] && cnt >= nw && $past(bus_ready) |-> cyc_done;
	endproperty
	a_rdy_end: assert property (p_rdy_end) else $error("cycle late after ready");
	property p_release;
		cyc_done |=> !cyc_done && nosel;
	endproperty
	a_release: assert property (p_release) else $error("select held after done");

	cover property (busy && !(&mid_mem_select_n));
	cover property (cyc_done && !cc[2] && cnt > nw);
	cover property (busy && !cm);
endmodule

bind csu_top csu_chk u_csu_chk(.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .cyc_start, .cyc_addr, .cyc_type, .bus_ready, .cyc_done,
	.boot_mem_select_n, .low_mem_select_n, .mid_mem_select_n);

// *** tb/csu_mem_model.sv ***
// Behavioural memory side: answers bus ready some cycles after it is selected.
// Assumes the bench raises pend for cycles that no select claims.
`timescale 1ns/1ps

module csu_mem_model (
	// Clock.
	input wire logic core_clk,
	// Selects and bench control.
	input wire logic boot_mem_select_n,
	input wire logic low_mem_select_n,
	input wire logic [3:0] mid_mem_select_n,
	input wire logic pend,
	input wire logic [3:0] lat,
	// Ready back to the decoder.
	output logic bus_ready
);
	logic [3:0] n = 4'h0;
	logic act;

	// A slow device holds ready low for lat cycles, so stalls come from here.
	assign act = pend || !boot_mem_select_n || !low_mem_select_n || !(&mid_mem_select_n);
	assign bus_ready = act && n >= lat;

	always @(posedge core_clk) begin
		n <= act ? (n == 4'hf ? n : n + 4'h1) : 4'h0;
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for csu_top: register port, select decode and wait states.
// Assumes csu_mem_model supplies bus ready and csu_chk is bound to the design.
`timescale 1ns/1ps

module tb_top;
	import csu_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [REG_ADDR_W-1:0] reg_addr = 3'h0;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic cyc_start = 1'b0;
	logic [ADDR_W-1:0] cyc_addr = 20'h00000;
	csu_cyc_type cyc_type = CYC_IDLE;
	logic bus_ready, cyc_done, boot_mem_select_n, low_mem_select_n;
	logic [3:0] mid_mem_select_n;
	logic pend = 1'b1;
	logic [3:0] lat = 4'h0;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;

	always #12.5 core_clk = ~core_clk;

	csu_top u_csu_top(.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.cyc_start, .cyc_addr, .cyc_type, .bus_ready, .cyc_done, .boot_mem_select_n,
		.low_mem_select_n, .mid_mem_select_n);
	csu_mem_model u_csu_mem_model(.core_clk, .boot_mem_select_n, .low_mem_select_n,
		.mid_mem_select_n, .pend, .lat, .bus_ready);

	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask

	// Checks the selects at edge 1, then the cycle length up to the done pulse.
	task automatic cyc(input logic [19:0] a, input csu_cyc_type t, input logic [5:0] s,
		input int n);
		int k;
		@(posedge core_clk);
		cyc_start <= 1'b1;
		cyc_addr <= a;
		cyc_type <= t;
		@(posedge core_clk);
		cyc_start <= 1'b0;
		#1 chk({10'h000, boot_mem_select_n, low_mem_select_n, mid_mem_select_n}, {10'h000, s});
		k = 1;
		while (cyc_done !== 1'b1 && k < 40) begin
			@(posedge core_clk);
			#1 k++;
		end
		chk(16'(k), 16'(n));
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 32'h0fa0) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		rd(OFF_STATUS, 16'h0001);
		cyc(20'h00000, CYC_MEM_READ, 6'h3f, 2);
		rd(OFF_BOOT, 16'h3fc3);
		cyc(20'hffc00, CYC_MEM_READ, 6'h1f, 5);
		cyc(20'hffbff, CYC_MEM_READ, 6'h3f, 2);
		rd(OFF_LOW, 16'h0003);
		rd(OFF_STATUS, 16'h0003);
		$display("test reset done");
		pend <= 1'b0;
		for (int g = 0; g < 2; g++) begin
			for (int w = 0; w < 8; w++) begin
				int m;
				int l;
				m = w % 4 + 2;
				l = g * 5 + 2;
				lat <= g ? 4'h5 : 4'h0;
				wr(OFF_BOOT, 16'h3c00 | 16'(w));
				cyc(20'hfc000, CYC_PREFETCH, 6'h1f, (w > 3 || m > l) ? m : l);
			end
		end
		$display("test wait done");
		rd(OFF_CYCLEN, 16'h0005);
		pend <= 1'b1;
		lat <= 4'h0;
		wr(OFF_LOW, 16'h0fc1);
		// Vectors go into low memory before any interrupt acknowledge cycle is run.
		cyc(20'h00000, CYC_MEM_WRITE, 6'h2f, 3);
		cyc(20'h0fbff, CYC_MEM_WRITE, 6'h2f, 3);
		cyc(20'h0fc00, CYC_MEM_READ, 6'h3f, 2);
		cyc(20'h4fbff, CYC_MEM_READ, 6'h3f, 2);
		for (int t = 3; t < 8; t++) begin
			cyc(20'hfc000, csu_cyc_type'(t), 6'h3f, 2);
		end
		$display("test low done");
		cyc(20'h80000, CYC_MEM_READ, 6'h3f, 2);
		wr(OFF_ALT, 16'h0400);
		wr(OFF_MID, 16'h8004);
		for (int q = 0; q < 4; q++) begin
			cyc(20'h80000 + 20'(q) * 20'h02000, CYC_MEM_READ, {2'h3, ~(4'h1 << q)}, 2);
		end
		cyc(20'h88000, CYC_MEM_READ, 6'h3f, 2);
		cyc(20'h7e000, CYC_MEM_READ, 6'h3f, 2);
		$display("test mid done");
		rd(OFF_MID, 16'h8004);
		wr(OFF_STATUS, 16'hffff);
		rd(OFF_STATUS, 16'h0007);
		rd(3'h6, 16'h0000);
		wr(OFF_LOW, 16'h3fc7);
		rd(OFF_LOW, 16'h3fc7);
		$display("test registers done");
		complete_run();
	end
endmodule
